// >>> core/mdsl_pkg.sv
package mdsl_pkg;
	// Frame fields
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [4:0] PHY_P1 = 5'h01;
	localparam logic [4:0] PHY_P2 = 5'h02;
	localparam logic [5:0] PRE_LEN = 6'h20;
	localparam logic [5:0] OP_LAST = 6'h01;
	localparam logic [5:0] PHY_LAST = 6'h04;
	localparam logic [5:0] ADR_LAST = 6'h09;
	localparam logic [5:0] TA_LAST = 6'h01;
	localparam logic [5:0] DAT_LAST = 6'h0F;
	// Direct register map
	localparam logic [4:0] R_BASE_CTRL = 5'h00;
	localparam logic [4:0] R_BASE_STAT = 5'h01;
	localparam logic [4:0] R_IDENT_UP = 5'h02;
	localparam logic [4:0] R_IDENT_LO = 5'h03;
	localparam logic [4:0] R_AN_LOCAL = 5'h04;
	localparam logic [4:0] R_AN_PARTNER = 5'h05;
	localparam logic [4:0] R_AN_EXP = 5'h06;
	localparam logic [4:0] R_AN_NP = 5'h07;
	localparam logic [4:0] R_AN_LP_NP = 5'h08;
	localparam logic [4:0] R_GIG_CTRL = 5'h09;
	localparam logic [4:0] R_GIG_STAT = 5'h0A;
	localparam logic [4:0] R_EXT_SETUP = 5'h0D;
	localparam logic [4:0] R_EXT_DATA = 5'h0E;
	localparam logic [4:0] R_EXT_STAT = 5'h0F;
	localparam logic [4:0] R_FAR_LOOP = 5'h11;
	localparam logic [4:0] R_CABLE_DIAG = 5'h12;
	localparam logic [4:0] R_PMA_STAT = 5'h13;
	localparam logic [4:0] R_RXERR_CNT = 5'h15;
	localparam logic [4:0] R_PORT_IRQ = 5'h1B;
	localparam logic [4:0] R_CROSSOVER = 5'h1C;
	localparam logic [4:0] R_MISC_CTRL = 5'h1F;
	localparam logic [31:0] IMPL_MASK = 32'h982E_E7FF;
	localparam logic [31:0] WR_MASK = 32'h9806_6291;
	// Byte window of a port: 0xN100 + 2*reg
	localparam logic [3:0] NIB_P1 = 4'h1;
	localparam logic [3:0] NIB_P2 = 4'h2;
	localparam logic [5:0] WIN_TAG = 6'h04;
	// Extended access setup function field [15:14]
	localparam int EXT_FN_MSB = 15;
	localparam int EXT_FN_LSB = 14;
	localparam logic [1:0] EXT_FN_ADDR = 2'h0;
	localparam logic [1:0] EXT_FN_INC_RW = 2'h2;
	localparam logic [1:0] EXT_FN_INC_WR = 2'h3;
	// Host port mode strap
	localparam logic [1:0] MODE_MGMT = 2'h2;
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	// Controller
	localparam int CLK_HZ = 20_000_000;
	localparam int MDC_MAX_HZ = 5_000_000;
	localparam int MDC_HALF_MIN = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
	localparam logic [6:0] FR_TA = 7'h2E;
	localparam logic [6:0] FR_DATA = 7'h30;
	localparam logic [6:0] FR_LAST = 7'h3F;
	localparam logic [31:0] FR_PRE = 32'hFFFF_FFFF;
	localparam logic [1:0] FR_SOF = 2'h1;
	localparam logic [1:0] FR_TA_WR = 2'h2;
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_WDATA = 8'h04;
	localparam logic [7:0] A_RDATA = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_DIV = 8'h10;
	localparam int CMD_START = 31;
	localparam int CMD_WRITE = 10;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_BLOCK = 2;
endpackage

// >>> core/mdsl_if.sv
`timescale 1ns/1ps
interface mdsl_if;
	logic mdc;
	logic ctl_o;
	logic ctl_oe;
	logic dev_o;
	logic dev_oe;
	logic mdio;
	// Pulled-up wire: the device can only pull low, the controller drives both levels
	assign mdio = ~(dev_oe & ~dev_o) & (ctl_oe ? ctl_o : 1'b1);
	modport ctl(output mdc, output ctl_o, output ctl_oe, input mdio);
	modport dev(input mdc, input mdio, output dev_o, output dev_oe);
endinterface

// >>> core/mdsl_dev.sv
// What this block does
// - Only PHY register sets are reachable here.
// - Link ignored while frame-based management runs.
// - Data line only pulled low or released.
// - Controller keeps management clock at most 5MHz.
// - Preamble, start, opcode, addresses, data MSB-first.
// - Turnaround: release, device drives zero, data.
// - PHY address 1 and 2 select ports.
// - Each port decodes 32 direct registers.
// - Register pair at 0xN100 plus twice address.
// - One storage shared with the byte host port.
// - Every data phase is exactly 16 bits.
// - Extended registers via setup Dh, data Eh.
// - Host port mode strapped at reset release.
`timescale 1ns/1ps
module mdsl_dev #(
	parameter logic [15:0] IDENT_UP = 16'h1234, // Arbitrary value
	parameter logic [15:0] IDENT_LO = 16'h5678, // Arbitrary value
	parameter int MMD_DEPTH = 8
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [1:0] MODE_STRAP,
	input wire logic FBM_EN,
	input wire logic [15:0] HOST_ADDR,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [7:0] HOST_WDATA,
	output logic [7:0] HOST_RDATA,
	output logic [1:0] HOST_MODE,
	mdsl_if.dev link
);
	localparam int AW = $clog2(MMD_DEPTH);
	typedef enum logic [2:0] {MDSL_PRE, MDSL_SOF, MDSL_OP, MDSL_ADR, MDSL_TA, MDSL_DAT} mdsl_st_t;

	// ---- Link clock domain ----
	mdsl_st_t st;
	logic [5:0] cnt;
	logic [1:0] op;
	logic [9:0] adr;
	logic [15:0] dat;
	logic hit;
	logic en_m1, en_m2, ack_m1, ack_m2;
	logic ack_tgl, link_en;
	logic req_tgl, req_wr, req_port;
	logic [4:0] req_reg;
	logic [15:0] req_data;
	logic oe;
	logic [15:0] snap [0:31];

	wire b = link.mdio;
	wire is_rd = (op == mdsl_pkg::OP_RD);
	wire [1:0] op_n = {op[0], b};
	wire [4:0] fld_n = {adr[3:0], b};
	wire phy_is_p1 = (fld_n == mdsl_pkg::PHY_P1);
	wire phy_ok = phy_is_p1 | (fld_n == mdsl_pkg::PHY_P2);
	wire rd_ok = (ack_m2 == req_tgl);
	wire [15:0] rd_val = snap[adr[4:0]];
	wire op_ok = (op_n == mdsl_pkg::OP_RD) | (op_n == mdsl_pkg::OP_WR);

	always_ff @(posedge link.mdc or negedge ARST_N) begin
		if (!ARST_N) begin
			en_m1 <= 1'b0;
			en_m2 <= 1'b0;
			ack_m1 <= 1'b0;
			ack_m2 <= 1'b0;
		end else begin
			en_m1 <= link_en;
			en_m2 <= en_m1;
			ack_m1 <= ack_tgl;
			ack_m2 <= ack_m1;
		end
	end

	always_ff @(posedge link.mdc or negedge ARST_N) begin
		if (!ARST_N) begin
			st <= MDSL_PRE;
			cnt <= '0;
			op <= '0;
			adr <= '0;
			dat <= '0;
			hit <= 1'b0;
			oe <= 1'b0;
			req_tgl <= 1'b0;
			req_wr <= 1'b0;
			req_port <= 1'b0;
			req_reg <= '0;
			req_data <= '0;
		end else begin
			case (st)
				MDSL_PRE: begin
					if (b) begin
						if (cnt != mdsl_pkg::PRE_LEN)
							cnt <= cnt + 6'h01;
					end else begin
						cnt <= '0;
						if (cnt == mdsl_pkg::PRE_LEN)
							st <= MDSL_SOF;
					end
				end
				MDSL_SOF: begin
					cnt <= '0;
					st <= b ? MDSL_OP : MDSL_PRE;
				end
				MDSL_OP: begin
					op <= op_n;
					cnt <= cnt + 6'h01;
					if (cnt == mdsl_pkg::OP_LAST) begin
						cnt <= '0;
						st <= op_ok ? MDSL_ADR : MDSL_PRE;
					end
				end
				MDSL_ADR: begin
					adr <= {adr[8:0], b};
					cnt <= cnt + 6'h01;
					if (cnt == mdsl_pkg::PHY_LAST) begin
						// Frames for other addresses fall through untouched
						hit <= en_m2 & phy_ok;
						req_port <= ~phy_is_p1;
						// Fetch the port's words early: the handshake needs a few link edges
						if (en_m2 & phy_ok & is_rd) begin
							req_wr <= 1'b0;
							req_tgl <= ~req_tgl;
						end
					end
					if (cnt == mdsl_pkg::ADR_LAST) begin
						cnt <= '0;
						st <= MDSL_TA;
					end
				end
				MDSL_TA: begin
					cnt <= cnt + 6'h01;
					if (cnt == '0)
						oe <= hit & is_rd & rd_ok;
					if (cnt == mdsl_pkg::TA_LAST) begin
						cnt <= '0;
						st <= MDSL_DAT;
						oe <= hit & is_rd & rd_ok & ~rd_val[15];
						dat <= {rd_val[14:0], 1'b0};
					end
				end
				MDSL_DAT: begin
					cnt <= cnt + 6'h01;
					if (is_rd) begin
						oe <= hit & rd_ok & ~dat[15];
						dat <= {dat[14:0], 1'b0};
					end else begin
						dat <= {dat[14:0], b};
					end
					if (cnt == mdsl_pkg::DAT_LAST) begin
						cnt <= '0;
						st <= MDSL_PRE;
						oe <= 1'b0;
						if (hit & ~is_rd) begin
							req_wr <= 1'b1;
							req_reg <= adr[4:0];
							req_data <= {dat[14:0], b};
							req_tgl <= ~req_tgl;
						end
					end
				end
				default: begin
					st <= MDSL_PRE;
					cnt <= '0;
					oe <= 1'b0;
				end
			endcase
		end
	end

	assign link.dev_oe = oe;
	assign link.dev_o = 1'b0;

	// ---- System clock domain ----
	logic [15:0] regs [0:63];
	logic [15:0] ext_addr [0:1];
	logic [15:0] mmd [0:2*MMD_DEPTH-1];
	logic [15:0] view [0:63];
	logic req_c1, req_c2;
	logic fbm_c1, fbm_c2;
	logic [1:0] strap_c1, strap_c2, strap_cnt, mode;

	genvar gi;
	for (gi = 0; gi < 64; gi++) begin : g_view
		localparam logic [4:0] RI = 5'(gi);
		localparam int PI = gi / 32;
		wire [1:0] fn = regs[{PI[0], mdsl_pkg::R_EXT_SETUP}][mdsl_pkg::EXT_FN_MSB:mdsl_pkg::EXT_FN_LSB];
		wire [15:0] ext_val = (fn == mdsl_pkg::EXT_FN_ADDR) ? ext_addr[PI] :
			mmd[{PI[0], ext_addr[PI][AW-1:0]}];
		assign view[gi] = !mdsl_pkg::IMPL_MASK[RI] ? 16'h0000 :
			(RI == mdsl_pkg::R_EXT_DATA) ? ext_val : regs[gi];
	end

	wire pend = (req_c2 != ack_tgl);
	wire link_do = pend & ~HOST_WR;
	wire [3:0] h_nib = HOST_ADDR[15:12];
	wire h_p2 = (h_nib == mdsl_pkg::NIB_P2);
	wire h_hit = (h_p2 | (h_nib == mdsl_pkg::NIB_P1)) & (HOST_ADDR[11:6] == mdsl_pkg::WIN_TAG);
	wire [5:0] h_idx = {h_p2, HOST_ADDR[5:1]};
	wire h_hi = ~HOST_ADDR[0];
	wire [15:0] h_old = view[h_idx];
	wire [15:0] h_val = h_hi ? {HOST_WDATA, h_old[7:0]} : {h_old[15:8], HOST_WDATA};
	wire w_en = HOST_WR ? h_hit : (link_do & req_wr);
	wire [5:0] w_idx = HOST_WR ? h_idx : {req_port, req_reg};
	wire [15:0] w_val = HOST_WR ? h_val : req_data;
	wire w_last = ~HOST_WR | ~h_hi;
	wire wp = w_idx[5];
	wire [4:0] wr = w_idx[4:0];
	wire [1:0] w_fn = regs[{wp, mdsl_pkg::R_EXT_SETUP}][mdsl_pkg::EXT_FN_MSB:mdsl_pkg::EXT_FN_LSB];
	wire w_inc = (w_fn == mdsl_pkg::EXT_FN_INC_RW) | (w_fn == mdsl_pkg::EXT_FN_INC_WR);

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			req_c1 <= 1'b0;
			req_c2 <= 1'b0;
			fbm_c1 <= 1'b0;
			fbm_c2 <= 1'b0;
			strap_c1 <= '0;
			strap_c2 <= '0;
			strap_cnt <= '0;
			mode <= '0;
			link_en <= 1'b0;
		end else begin
			req_c1 <= req_tgl;
			req_c2 <= req_c1;
			fbm_c1 <= FBM_EN;
			fbm_c2 <= fbm_c1;
			strap_c1 <= MODE_STRAP;
			strap_c2 <= strap_c1;
			if (strap_cnt != mdsl_pkg::STRAP_WAIT)
				strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == mdsl_pkg::STRAP_WAIT - 2'h1)
				mode <= strap_c2;
			link_en <= (mode == mdsl_pkg::MODE_MGMT) & (strap_cnt == mdsl_pkg::STRAP_WAIT) & ~fbm_c2;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_tgl <= 1'b0;
			HOST_RDATA <= '0;
			for (int i = 0; i < 64; i++)
				regs[i] <= (i % 32 == 2) ? IDENT_UP : (i % 32 == 3) ? IDENT_LO : 16'h0000;
			for (int i = 0; i < 2; i++)
				ext_addr[i] <= '0;
			for (int i = 0; i < 2 * MMD_DEPTH; i++)
				mmd[i] <= '0;
			for (int i = 0; i < 32; i++)
				snap[i] <= '0;
		end else begin
			if (HOST_RD)
				HOST_RDATA <= !h_hit ? 8'h00 : h_hi ? h_old[15:8] : h_old[7:0];
			if (link_do) begin
				ack_tgl <= req_c2;
				if (!req_wr) begin
					for (int i = 0; i < 32; i++)
						snap[i] <= view[{req_port, 5'(i)}];
				end
			end
			if (w_en & mdsl_pkg::WR_MASK[wr]) begin
				if (wr == mdsl_pkg::R_EXT_DATA) begin
					if (w_fn == mdsl_pkg::EXT_FN_ADDR)
						ext_addr[wp] <= w_val;
					else
						mmd[{wp, ext_addr[wp][AW-1:0]}] <= w_val;
					if (w_fn != mdsl_pkg::EXT_FN_ADDR && w_inc && w_last)
						ext_addr[wp] <= ext_addr[wp] + 16'h0001;
				end else begin
					regs[w_idx] <= w_val;
				end
			end
		end
	end

	assign HOST_MODE = mode;
endmodule

// >>> core/mdsl_ctl.sv
`timescale 1ns/1ps
module mdsl_ctl #(
	parameter logic [7:0] MDC_HALF = 8'h02
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic FBM_EN,
	mdsl_if.ctl link
);
	logic [10:0] cmd;
	logic [15:0] wdata, rdata;
	logic [7:0] half, div;
	logic busy, done, blocked, mdc, d_o, d_oe;
	logic [6:0] bit_i;
	logic [63:0] fr;
	logic m1, m2, f1, f2;

	wire acc = PSEL & PENABLE & PREADY;
	wire wr_cmd = acc & PWRITE & (PADDR == mdsl_pkg::A_CMD);
	wire wr_stat = acc & PWRITE & (PADDR == mdsl_pkg::A_STAT);
	wire go = wr_cmd & PWDATA[mdsl_pkg::CMD_START] & ~busy;
	wire go_ok = go & ~f2;
	wire [7:0] half_eff = (half < 8'(mdsl_pkg::MDC_HALF_MIN)) ? 8'(mdsl_pkg::MDC_HALF_MIN) : half;
	wire tick = busy & (div == half_eff - 8'h01);
	wire rise = tick & ~mdc;
	wire fall = tick & mdc;
	wire fin = fall & (bit_i == mdsl_pkg::FR_LAST);
	wire is_wr = cmd[mdsl_pkg::CMD_WRITE];
	wire [6:0] nxt_i = bit_i + 7'h01;
	wire [1:0] op = PWDATA[mdsl_pkg::CMD_WRITE] ? mdsl_pkg::OP_WR : mdsl_pkg::OP_RD;
	wire [1:0] ta = PWDATA[mdsl_pkg::CMD_WRITE] ? mdsl_pkg::FR_TA_WR : 2'h0;
	wire [63:0] fr_new = {mdsl_pkg::FR_PRE, mdsl_pkg::FR_SOF, op, PWDATA[9:0], ta, wdata};
	wire mapped = (PADDR == mdsl_pkg::A_CMD) | (PADDR == mdsl_pkg::A_WDATA) | (PADDR == mdsl_pkg::A_RDATA) |
		(PADDR == mdsl_pkg::A_STAT) | (PADDR == mdsl_pkg::A_DIV);
	wire [31:0] stat = {29'h0, blocked, done, busy};
	wire [31:0] rd_mux = (PADDR == mdsl_pkg::A_CMD) ? {21'h0, cmd} :
		(PADDR == mdsl_pkg::A_WDATA) ? {16'h0, wdata} :
		(PADDR == mdsl_pkg::A_RDATA) ? {16'h0, rdata} :
		(PADDR == mdsl_pkg::A_STAT) ? stat :
		(PADDR == mdsl_pkg::A_DIV) ? {24'h0, half} : 32'h0;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= '0;
			m1 <= 1'b1;
			m2 <= 1'b1;
			f1 <= 1'b0;
			f2 <= 1'b0;
		end else begin
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~mapped;
			PRDATA <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : 32'h0;
			m1 <= link.mdio;
			m2 <= m1;
			f1 <= FBM_EN;
			f2 <= f1;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cmd <= '0;
			wdata <= '0;
			half <= MDC_HALF;
			done <= 1'b0;
			blocked <= 1'b0;
		end else begin
			if (wr_cmd & ~busy)
				cmd <= PWDATA[10:0];
			if (acc & PWRITE & (PADDR == mdsl_pkg::A_WDATA))
				wdata <= PWDATA[15:0];
			if (acc & PWRITE & (PADDR == mdsl_pkg::A_DIV))
				half <= PWDATA[7:0];
			// A finishing frame wins over a clear in the same cycle
			done <= fin | (done & ~(wr_stat & PWDATA[mdsl_pkg::STAT_DONE]));
			blocked <= (go & f2) | (blocked & ~(wr_stat & PWDATA[mdsl_pkg::STAT_BLOCK]));
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			busy <= 1'b0;
			div <= '0;
			mdc <= 1'b0;
			bit_i <= '0;
			fr <= '0;
			d_o <= 1'b1;
			d_oe <= 1'b0;
			rdata <= '0;
		end else if (go_ok) begin
			busy <= 1'b1;
			div <= '0;
			mdc <= 1'b0;
			bit_i <= '0;
			fr <= fr_new;
			d_o <= fr_new[63];
			d_oe <= 1'b1;
		end else if (busy) begin
			div <= tick ? 8'h00 : div + 8'h01;
			if (tick)
				mdc <= ~mdc;
			if (rise & ~is_wr & (bit_i >= mdsl_pkg::FR_DATA))
				rdata <= {rdata[14:0], m2};
			if (fin) begin
				busy <= 1'b0;
				d_oe <= 1'b0;
				d_o <= 1'b1;
			end else if (fall) begin
				bit_i <= nxt_i;
				fr <= {fr[62:0], 1'b0};
				d_o <= fr[62];
				d_oe <= is_wr | (nxt_i < mdsl_pkg::FR_TA);
			end
		end
	end

	assign link.mdc = mdc;
	assign link.ctl_o = d_o;
	assign link.ctl_oe = d_oe;
endmodule

// >>> tb/mdsl_link_properties.sv
`timescale 1ns/1ps
module mdsl_link_properties (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic mdc,
	input wire logic ctl_o,
	input wire logic ctl_oe,
	input wire logic dev_o,
	input wire logic dev_oe,
	input wire logic mdio,
	input wire logic dev_on
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	logic mdc_q;
	logic oe_q;
	logic rd_op;
	logic [4:0] phy;
	logic [6:0] fcnt;
	wire fall = mdc_q & ~mdc;
	wire [6:0] idx = fcnt + 7'h01;
	wire phy_ok = (phy == mdsl_pkg::PHY_P1) || (phy == mdsl_pkg::PHY_P2);
	// At a detected falling edge, idx is the bit now on the wire
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mdc_q <= 1'b0;
			oe_q <= 1'b0;
			rd_op <= 1'b0;
			phy <= 5'h00;
			fcnt <= 7'h00;
		end else begin
			mdc_q <= mdc;
			oe_q <= ctl_oe;
			if (ctl_oe && !oe_q) begin
				fcnt <= 7'h00;
			end else if (fall) begin
				fcnt <= idx;
			end
			if (fall && idx == 7'h22) begin
				rd_op <= ctl_o;
			end
			if (fall && idx >= 7'h24 && idx <= 7'h28) begin
				phy <= {phy[3:0], ctl_o};
			end
		end
	end
	a_preamble_ones: assert property (fall && idx < 7'h20 |-> ctl_oe && ctl_o) else $error("preamble bit not one");
	a_start_pattern: assert property (fall && idx == 7'h20 |-> !ctl_o ##4 (fall && ctl_o)) else $error("bad start");
	a_read_release: assert property (fall && idx == 7'h2E && rd_op |-> !ctl_oe && !dev_oe) else $error("ta not free");
	a_write_ta: assert property (fall && idx == 7'h2E && !rd_op |-> ctl_o ##4 (fall && !ctl_o)) else $error("write ta");
	a_ta_zero: assert property (fall && idx == 7'h2F && rd_op && phy_ok && dev_on |-> dev_oe && !mdio)
		else $error("no ta zero");
	a_disabled_quiet: assert property (!dev_on |-> !dev_oe) else $error("disabled link driven");
	a_foreign_quiet: assert property (fall && idx > 7'h28 && !phy_ok |-> !dev_oe) else $error("foreign phy driven");
	a_frame_end: assert property (fall && idx == 7'h40 |-> !ctl_oe && !dev_oe) else $error("line not released");
	a_open_drain: assert property (dev_oe |-> !dev_o && !ctl_oe) else $error("device drives high or contends");
	a_dev_on_rise: assert property ($changed(dev_oe) |-> mdc) else $error("device changed off rising edge");
	a_mdc_rate: assert property ($rose(mdc) |-> mdc ##1 mdc ##1 !mdc) else $error("mdc half period wrong");
	c_read_frame: cover property (fall && idx == 7'h2F && rd_op && phy_ok);
	c_write_frame: cover property (fall && idx == 7'h2F && !rd_op);
	c_foreign_frame: cover property (fall && idx == 7'h29 && !phy_ok);
endmodule

// >>> tb/mdsl_bench.sv
`timescale 1ns/1ps
module mdsl_bench;
	localparam logic [15:0] ID_UP = 16'hA5C3; // Arbitrary value
	localparam logic [15:0] ID_LO = 16'h3C5A; // Arbitrary value
	logic clk, arst_n, fbm_en, psel, penable, pwrite, pready, pslverr, h_wr, h_rd;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [15:0] h_addr;
	logic [7:0] h_wdata;
	logic [7:0] h_rdata;
	logic [1:0] h_mode;
	logic [1:0] strap;
	logic fbm_dev;
	wire dev_on = (strap == mdsl_pkg::MODE_MGMT) & ~fbm_dev;
	int miscompares;
	int total_checks;
	mdsl_if link_if();
	mdsl_dev #(.IDENT_UP(ID_UP), .IDENT_LO(ID_LO)) u_mdsl_dev (.CLK(clk), .ARST_N(arst_n),
		.MODE_STRAP(strap), .FBM_EN(fbm_dev), .HOST_ADDR(h_addr), .HOST_WR(h_wr), .HOST_RD(h_rd),
		.HOST_WDATA(h_wdata), .HOST_RDATA(h_rdata), .HOST_MODE(h_mode), .link(link_if));
	mdsl_ctl u_mdsl_ctl (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.FBM_EN(fbm_en), .link(link_if));
	mdsl_link_properties u_mdsl_link_properties (.CLK(clk), .ARST_N(arst_n), .mdc(link_if.mdc),
		.ctl_o(link_if.ctl_o), .ctl_oe(link_if.ctl_oe), .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe),
		.mdio(link_if.mdio), .dev_on(dev_on));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic link_op(input logic [4:0] phy, input logic [4:0] rg, input logic wr, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [31:0] d;
		logic e;
		apb(1'b1, mdsl_pkg::A_WDATA, {16'h0000, wd}, d, e);
		apb(1'b1, mdsl_pkg::A_CMD, 32'h8000_0000 | {21'h000000, wr, phy, rg}, d, e);
		do begin
			apb(1'b0, mdsl_pkg::A_STAT, 32'h0, d, e);
		end while (d[mdsl_pkg::STAT_DONE] !== 1'b1);
		apb(1'b1, mdsl_pkg::A_STAT, 32'h2, d, e);
		apb(1'b0, mdsl_pkg::A_RDATA, 32'h0, d, e);
		rd = d[15:0];
	endtask
	function automatic logic [15:0] baddr(input logic [3:0] n, input logic [4:0] rg);
		return {n, 12'h100} + {10'h000, rg, 1'b0};
	endfunction
	task automatic byte_rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		h_rd <= 1'b1;
		h_addr <= a;
		@(posedge clk);
		h_rd <= 1'b0;
		#1 d = h_rdata;
	endtask
	task automatic byte_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		h_wr <= 1'b1;
		h_addr <= a;
		h_wdata <= d;
		@(posedge clk);
		h_wr <= 1'b0;
	endtask
	task automatic t_ident();
		logic [15:0] r;
		check({30'h0, h_mode}, {30'h0, mdsl_pkg::MODE_MGMT});
		for (int p = 1; p <= 2; p++) begin
			link_op(5'(p), mdsl_pkg::R_IDENT_UP, 1'b0, 16'h0000, r);
			check({16'h0, r}, {16'h0, ID_UP});
			link_op(5'(p), mdsl_pkg::R_IDENT_LO, 1'b0, 16'h0000, r);
			check({16'h0, r}, {16'h0, ID_LO});
		end
	endtask
	task automatic t_shared();
		logic [15:0] r;
		logic [7:0] b;
		for (int p = 1; p <= 2; p++) begin
			link_op(5'(p), mdsl_pkg::R_MISC_CTRL, 1'b1, 16'h5A00 | 16'(p), r);
			byte_rd(baddr(4'(p), mdsl_pkg::R_MISC_CTRL), b);
			check({24'h0, b}, 32'h5A);
			byte_rd(baddr(4'(p), mdsl_pkg::R_MISC_CTRL) + 16'h1, b);
			check({24'h0, b}, 32'(p));
		end
		byte_wr(baddr(4'h1, mdsl_pkg::R_AN_LOCAL), 8'hC3);
		byte_wr(baddr(4'h1, mdsl_pkg::R_AN_LOCAL) + 16'h1, 8'h81);
		link_op(5'h01, mdsl_pkg::R_AN_LOCAL, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'hC381);
		link_op(5'h02, mdsl_pkg::R_AN_LOCAL, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'h0);
	endtask
	task automatic t_unimpl();
		logic [15:0] r;
		logic [4:0] regs [4] = '{5'h0B, 5'h10, 5'h1D, mdsl_pkg::R_BASE_STAT};
		foreach (regs[i]) begin
			link_op(5'h01, regs[i], 1'b1, 16'hFFFF, r);
			link_op(5'h01, regs[i], 1'b0, 16'h0000, r);
			check({16'h0, r}, 32'h0);
		end
	endtask
	task automatic t_foreign();
		logic [15:0] r;
		logic [4:0] phys [2] = '{5'h00, 5'h03};
		foreach (phys[i]) begin
			link_op(phys[i], mdsl_pkg::R_MISC_CTRL, 1'b1, 16'h0F0F, r);
			link_op(phys[i], mdsl_pkg::R_MISC_CTRL, 1'b0, 16'h0000, r);
			check({16'h0, r}, 32'hFFFF);
		end
		link_op(5'h01, mdsl_pkg::R_MISC_CTRL, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'h5A01);
	endtask
	task automatic t_ext();
		logic [15:0] r;
		logic [4:0] rg [4] = '{mdsl_pkg::R_EXT_SETUP, mdsl_pkg::R_EXT_DATA, mdsl_pkg::R_EXT_SETUP, mdsl_pkg::R_EXT_DATA};
		logic [15:0] wd [4] = '{16'h0007, 16'h0005, 16'h4007, 16'hBEEF};
		foreach (rg[i]) begin
			link_op(5'h02, rg[i], 1'b1, wd[i], r);
		end
		link_op(5'h02, mdsl_pkg::R_EXT_DATA, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'hBEEF);
		link_op(5'h02, mdsl_pkg::R_EXT_SETUP, 1'b1, 16'h0007, r);
		link_op(5'h02, mdsl_pkg::R_EXT_DATA, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'h0005);
		// Post-increment mode: a write moves the pointer, a read does not
		link_op(5'h02, mdsl_pkg::R_EXT_SETUP, 1'b1, 16'h8007, r);
		link_op(5'h02, mdsl_pkg::R_EXT_DATA, 1'b1, 16'h1111, r);
		link_op(5'h02, mdsl_pkg::R_EXT_DATA, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'h0);
		link_op(5'h02, mdsl_pkg::R_EXT_SETUP, 1'b1, 16'h0007, r);
		link_op(5'h02, mdsl_pkg::R_EXT_DATA, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'h0006);
	endtask
	task automatic t_block();
		logic [31:0] d;
		logic [15:0] r;
		logic e;
		fbm_en <= 1'b1;
		repeat (6) @(posedge clk);
		apb(1'b1, mdsl_pkg::A_CMD, 32'h8000_0021, d, e);
		repeat (20) @(posedge clk);
		check({31'h0, link_if.ctl_oe}, 32'h0);
		apb(1'b0, mdsl_pkg::A_STAT, 32'h0, d, e);
		check(d & 32'h7, 32'h4);
		apb(1'b1, mdsl_pkg::A_STAT, 32'h4, d, e);
		fbm_en <= 1'b0;
		apb(1'b0, mdsl_pkg::A_STAT, 32'h0, d, e);
		check(d & 32'h7, 32'h0);
		apb(1'b0, 8'h20, 32'h0, d, e);
		check({31'h0, e}, 32'h1);
		check(d, 32'h0);
		// Device side alone in frame-based mode: frames must fall through
		fbm_dev <= 1'b1;
		repeat (6) @(posedge clk);
		link_op(5'h01, mdsl_pkg::R_MISC_CTRL, 1'b1, 16'h1234, r);
		link_op(5'h01, mdsl_pkg::R_MISC_CTRL, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'hFFFF);
		fbm_dev <= 1'b0;
		repeat (6) @(posedge clk);
		link_op(5'h01, mdsl_pkg::R_MISC_CTRL, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'h5A01);
	endtask
	task automatic t_strap();
		logic [15:0] r;
		strap <= 2'h1;
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge clk);
		check({30'h0, h_mode}, 32'h1);
		link_op(5'h01, mdsl_pkg::R_IDENT_UP, 1'b0, 16'h0000, r);
		check({16'h0, r}, 32'hFFFF);
		strap <= mdsl_pkg::MODE_MGMT;
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge clk);
		check({30'h0, h_mode}, {30'h0, mdsl_pkg::MODE_MGMT});
		link_op(5'h01, mdsl_pkg::R_IDENT_UP, 1'b0, 16'h0000, r);
		check({16'h0, r}, {16'h0, ID_UP});
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{fbm_en, fbm_dev, psel, penable, pwrite, h_wr, h_rd} = 7'h00;
		strap = mdsl_pkg::MODE_MGMT;
		// Scheduled so that every async reset, link side too, sees the edge at time zero
		arst_n <= 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		h_addr = 16'h0000;
		h_wdata = 8'h00;
		miscompares = 0;
		total_checks = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge clk);
		t_ident();
		t_shared();
		t_unimpl();
		t_foreign();
		t_ext();
		t_block();
		t_strap();
		summarize();
	end
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		summarize();
	end
endmodule
